// ### src/tape_pkg.sv
// Purpose: shared constants and types for the tape write/gap sequencer
// Assumes: 50 MHz mclk, 800 bpi, one motor step per character space
// Notes:   counts above 4096 cycles are defaults for top-level parameters
package tape_pkg;

  // clock
  localparam int unsigned CLK_HZ  = 50_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

  // oscillator pulse width, least time, rounded up
  localparam int unsigned OSC_PULSE_US  = 10;
  localparam int unsigned OSC_PULSE_CYC = OSC_PULSE_US * CLK_MHZ;

  // nominal stepping rate
  localparam int unsigned STEP_RATE_HZ    = 1000;
  localparam int unsigned STEP_PERIOD_CYC = CLK_HZ / STEP_RATE_HZ;

  // acceleration ramp, plain defaults
  localparam int unsigned ACCEL_START_US  = 4000;
  localparam int unsigned ACCEL_START_CYC = ACCEL_START_US * CLK_MHZ;
  localparam int unsigned ACCEL_DEC_US    = 500;
  localparam int unsigned ACCEL_DEC_CYC   = ACCEL_DEC_US * CLK_MHZ;

  // echo check window after a write step, longest time, rounded down
  localparam int unsigned ECHO_WINDOW_US  = 1950;
  localparam int unsigned ECHO_WINDOW_CYC = ECHO_WINDOW_US * CLK_MHZ;

  // stopping delay appended to each gap, plain default
  localparam int unsigned STOP_DELAY_MS  = 20;
  localparam int unsigned STOP_DELAY_CYC = STOP_DELAY_MS * (CLK_HZ / 1000);

  // gap lengths in character spaces
  localparam int unsigned DENSITY_BPI  = 800;
  localparam int unsigned REC_GAP_MIL  = 600;
  localparam int unsigned FILE_GAP_MIL = 3750;
  localparam int unsigned BOT_GAP_MIL  = 500;

  typedef logic [11:0] space_t;
  typedef logic [23:0] cnt_t;

  localparam space_t REC_GAP_SP  = space_t'(REC_GAP_MIL * DENSITY_BPI / 1000);
  localparam space_t FILE_GAP_SP = space_t'(FILE_GAP_MIL * DENSITY_BPI / 1000);
  localparam space_t BOT_GAP_SP  = space_t'(BOT_GAP_MIL * DENSITY_BPI / 1000);
  localparam space_t CRC_SPACE   = 12'h004;
  localparam space_t LCC_SPACE   = 12'h008;

  // characters
  localparam logic [7:0] MARK_CHAR = 8'hC8;
  // check polynomial feedback, arbitrary default
  localparam logic [7:0] CRC_POLY  = 8'h1D;
  localparam logic [7:0] ZERO_CHAR = 8'h00;

  // synchronised input vector layout
  localparam int unsigned NIN       = 22;
  localparam int unsigned I_DATA    = 0;
  localparam int unsigned I_WSTEP   = 8;
  localparam int unsigned I_EOR     = 9;
  localparam int unsigned I_EOF     = 10;
  localparam int unsigned I_FWD     = 11;
  localparam int unsigned I_SLEW    = 12;
  localparam int unsigned I_LP      = 13;
  localparam int unsigned I_TE      = 14;
  localparam int unsigned I_BRK     = 15;
  localparam int unsigned I_ECHO    = 16;
  localparam int unsigned I_HOK     = 17;
  localparam int unsigned I_LOAD_N  = 18;
  localparam int unsigned I_REW_N   = 19;
  localparam int unsigned I_FILE_N  = 20;
  localparam int unsigned I_RDY_N   = 21;
  // ground closures idle high, so their stages reset high
  localparam logic [NIN-1:0] SYNC_RST = 22'h3C_0000;

  typedef enum logic [2:0] {S_UNLOADED, S_LOADING, S_REWIND, S_READY, S_GAP, S_STOP} state_t;
  typedef enum logic [1:0] {G_BOT, G_REC, G_FILE, G_MARK} gap_t;

endpackage

// ### src/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q, s2_q, s3_q, out_q;
      logic out_d;
      always_comb begin
        out_d = (s2_q == s3_q) ? s2_q : out_q;
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          s1_q  <= RST_VAL[g];
          s2_q  <= RST_VAL[g];
          s3_q  <= RST_VAL[g];
          out_q <= RST_VAL[g];
        end else if (ce) begin
          s1_q  <= raw[g];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          out_q <= out_d;
        end
      end
      assign clean[g] = out_q;
    end
  endgenerate

endmodule // pin_sync

// ### src/tape_write_gap_sequencer.sv
// Purpose: write-side sequencer of an incremental nine-track recorder
// Assumes: one clock, synchronous reset, every pin passes pin_sync
// Notes:   motor steps are one per character space
//
// Implementation choices: the plain strobed port.
`timescale 1ns/1ps
module tape_write_gap_sequencer #(
  parameter int unsigned STEP_PERIOD_CYC = tape_pkg::STEP_PERIOD_CYC,
  parameter int unsigned ACCEL_START_CYC = tape_pkg::ACCEL_START_CYC,
  parameter int unsigned ACCEL_DEC_CYC   = tape_pkg::ACCEL_DEC_CYC,
  parameter int unsigned ECHO_WINDOW_CYC = tape_pkg::ECHO_WINDOW_CYC,
  parameter int unsigned STOP_DELAY_CYC  = tape_pkg::STOP_DELAY_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] data_in,
  input  wire logic       write_step,
  input  wire logic       end_record_command,
  input  wire logic       end_file_command,
  input  wire logic       forward_select,
  input  wire logic       slew,
  input  wire logic       load_point_sense,
  input  wire logic       tape_end_sense,
  input  wire logic       broken_tape_sense,
  input  wire logic       echo_fault,
  input  wire logic       head_current_ok,
  input  wire logic       load_forward_n,
  input  wire logic       rewind_n,
  input  wire logic       file_gap_n,
  input  wire logic       ready_button_n,
  output logic            motor_step,
  output logic            motor_forward,
  output logic            rewind_drive,
  output logic            head_write,
  output logic [8:0]      head_char,
  output logic            ready,
  output logic            gap_active,
  output logic            write_error,
  output logic            load_point,
  output logic            tape_end_marker,
  output logic            osc_out
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);

  function automatic logic [8:0] odd_char(input logic [7:0] b);
    return {~^b, b};
  endfunction

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] ch);
    logic [7:0] x;
    x = c ^ ch;
    return {x[6:0], 1'b0} ^ (x[7] ? tape_pkg::CRC_POLY : tape_pkg::ZERO_CHAR);
  endfunction

  function automatic tape_pkg::space_t gap_len(input tape_pkg::gap_t k);
    case (k)
      tape_pkg::G_BOT:  return tape_pkg::BOT_GAP_SP;
      tape_pkg::G_FILE: return tape_pkg::FILE_GAP_SP;
      default:          return tape_pkg::REC_GAP_SP;
    endcase
  endfunction

  localparam tape_pkg::cnt_t PULSE_C = tape_pkg::cnt_t'(tape_pkg::OSC_PULSE_CYC);
  localparam tape_pkg::cnt_t PER_C   = tape_pkg::cnt_t'(STEP_PERIOD_CYC);
  localparam tape_pkg::cnt_t START_C = tape_pkg::cnt_t'(ACCEL_START_CYC);
  localparam tape_pkg::cnt_t DEC_C   = tape_pkg::cnt_t'(ACCEL_DEC_CYC);
  localparam tape_pkg::cnt_t ECHO_C  = tape_pkg::cnt_t'(ECHO_WINDOW_CYC);
  localparam tape_pkg::cnt_t STOP_C  = tape_pkg::cnt_t'(STOP_DELAY_CYC);
  localparam tape_pkg::cnt_t ONE_C   = 24'h00_0001;

  logic [tape_pkg::NIN-1:0] raw, cln;

  assign raw = {ready_button_n, file_gap_n, rewind_n, load_forward_n, head_current_ok, echo_fault,
                broken_tape_sense, tape_end_sense, load_point_sense, slew, forward_select,
                end_file_command, end_record_command, write_step, data_in};

  pin_sync #(.W(tape_pkg::NIN), .RST_VAL(tape_pkg::SYNC_RST)) u_sync (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .raw   (raw),
    .clean (cln)
  );

  logic [7:0] data_s;
  logic       fwd_s, slew_s, lp_s, te_s, brk_s, echo_s, hok_s;
  logic       load_p, rew_p, file_p, rdy_p;
  assign data_s = cln[tape_pkg::I_DATA +: 8];
  assign fwd_s  = cln[tape_pkg::I_FWD];
  assign slew_s = cln[tape_pkg::I_SLEW];
  assign lp_s   = cln[tape_pkg::I_LP];
  assign te_s   = cln[tape_pkg::I_TE];
  assign brk_s  = cln[tape_pkg::I_BRK];
  assign echo_s = cln[tape_pkg::I_ECHO];
  assign hok_s  = cln[tape_pkg::I_HOK];
  assign load_p = ~cln[tape_pkg::I_LOAD_N];
  assign rew_p  = ~cln[tape_pkg::I_REW_N];
  assign file_p = ~cln[tape_pkg::I_FILE_N];
  assign rdy_p  = ~cln[tape_pkg::I_RDY_N];

  // sequencer state
  tape_pkg::state_t state_q, state_d;
  tape_pkg::gap_t   gap_q, gap_d;
  tape_pkg::space_t sp_q, sp_d, sp_n;
  tape_pkg::cnt_t   tmr_q, tmr_d;
  logic [7:0] crc_q, crc_d, lcc_q, lcc_d;
  logic [8:0] head_char_q, head_char_d;
  logic [3:0] prev_q, prev_d;
  logic dirty_q, dirty_d, crc_pend_q, crc_pend_d, lcc_pend_q, lcc_pend_d, loaded_q, loaded_d;
  logic head_wr_q, head_wr_d, ready_q, ready_d, gap_act_q, gap_act_d, rew_q, rew_d;
  logic lp_q, te_q, fwd_q, fwd_d;
  logic ws_rise, eor_rise, eof_rise, step_take, osc_tick;

  assign prev_d   = {file_p, cln[tape_pkg::I_EOF], cln[tape_pkg::I_EOR], cln[tape_pkg::I_WSTEP]};
  assign ws_rise  = prev_d[0] & ~prev_q[0];
  assign eor_rise = prev_d[1] & ~prev_q[1];
  assign eof_rise = (prev_d[2] & ~prev_q[2]) | (prev_d[3] & ~prev_q[3]);

  always_comb begin
    state_d = state_q;  gap_d = gap_q;  sp_d = sp_q;  sp_n = sp_q + 12'h001;  tmr_d = tmr_q;
    crc_d = crc_q;  lcc_d = lcc_q;  dirty_d = dirty_q;  loaded_d = loaded_q;
    crc_pend_d = crc_pend_q;  lcc_pend_d = lcc_pend_q;
    head_wr_d = 1'b0;  head_char_d = head_char_q;  step_take = 1'b0;
    case (state_q)
      tape_pkg::S_UNLOADED: begin
        loaded_d = 1'b0;
        if (load_p && rdy_p) begin
          state_d  = tape_pkg::S_READY;
          loaded_d = 1'b1;
        end else if (load_p) begin
          state_d = tape_pkg::S_LOADING;
        end
      end
      tape_pkg::S_LOADING: begin
        if (lp_s) begin
          state_d = tape_pkg::S_GAP;
          gap_d   = tape_pkg::G_BOT;
          sp_d    = '0;
        end
      end
      tape_pkg::S_REWIND: begin
        if (lp_s) begin
          state_d = tape_pkg::S_UNLOADED;
        end
      end
      tape_pkg::S_READY: begin
        if (rew_p) begin
          state_d  = tape_pkg::S_REWIND;
          loaded_d = 1'b0;
        end else if (eof_rise || eor_rise) begin
          state_d    = tape_pkg::S_GAP;
          gap_d      = eof_rise ? tape_pkg::G_FILE : tape_pkg::G_REC;
          sp_d       = '0;
          crc_pend_d = dirty_q;
          lcc_pend_d = dirty_q;
        end else if (ws_rise && loaded_q && hok_s) begin
          step_take   = 1'b1;
          head_wr_d   = 1'b1;
          head_char_d = odd_char(data_s);
          crc_d       = crc_step(crc_q, data_s);
          lcc_d       = lcc_q ^ data_s;
          dirty_d     = 1'b1;
        end
      end
      tape_pkg::S_GAP: begin
        if (osc_tick) begin
          sp_d = sp_n;
          if (gap_q != tape_pkg::G_MARK) begin
            if (crc_pend_q && sp_n == tape_pkg::CRC_SPACE) begin
              head_wr_d   = 1'b1;
              head_char_d = odd_char(crc_q);
              lcc_d       = lcc_q ^ crc_q;
              crc_pend_d  = 1'b0;
            end
            if (lcc_pend_q && sp_n == tape_pkg::LCC_SPACE) begin
              head_wr_d   = 1'b1;
              head_char_d = odd_char(lcc_q);
              lcc_pend_d  = 1'b0;
            end
          end else if (sp_n == tape_pkg::LCC_SPACE) begin
            // mark check only, no cyclic check
            head_wr_d   = 1'b1;
            head_char_d = odd_char(tape_pkg::MARK_CHAR);
          end
          if (sp_n == gap_len(gap_q)) begin
            if (gap_q == tape_pkg::G_FILE) begin
              // mark then its check and a record gap
              gap_d       = tape_pkg::G_MARK;
              sp_d        = '0;
              head_wr_d   = 1'b1;
              head_char_d = odd_char(tape_pkg::MARK_CHAR);
            end else begin
              state_d = tape_pkg::S_STOP;
              tmr_d   = '0;
              crc_d   = '0;
              lcc_d   = '0;
              dirty_d = 1'b0;
            end
          end
        end
      end
      tape_pkg::S_STOP: begin
        tmr_d = tmr_q + ONE_C;
        if (tmr_q >= STOP_C - ONE_C) begin
          state_d = tape_pkg::S_READY;
          if (gap_q == tape_pkg::G_BOT) begin
            loaded_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = tape_pkg::S_UNLOADED;
      end
    endcase
    if (brk_s) begin
      state_d   = tape_pkg::S_UNLOADED;
      loaded_d  = 1'b0;
      head_wr_d = 1'b0;
      step_take = 1'b0;
    end
    // ready needs load and head current
    ready_d   = loaded_d & hok_s;
    gap_act_d = (state_d == tape_pkg::S_GAP) || (state_d == tape_pkg::S_STOP);
    rew_d     = (state_d == tape_pkg::S_REWIND);
    // direction select only in ready; rewind runs reverse
    fwd_d     = rew_d ? 1'b0 : ((state_d == tape_pkg::S_READY) ? fwd_s : 1'b1);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= tape_pkg::S_UNLOADED;  gap_q <= tape_pkg::G_BOT;  sp_q <= '0;  tmr_q <= '0;
      crc_q <= '0;  lcc_q <= '0;  head_char_q <= '0;  prev_q <= '0;
      dirty_q <= 1'b0;  crc_pend_q <= 1'b0;  lcc_pend_q <= 1'b0;  loaded_q <= 1'b0;
      head_wr_q <= 1'b0;  ready_q <= 1'b0;  gap_act_q <= 1'b0;  rew_q <= 1'b0;
      lp_q <= 1'b0;  te_q <= 1'b0;  fwd_q <= 1'b1;
    end else if (ce) begin
      state_q <= state_d;  gap_q <= gap_d;  sp_q <= sp_d;  tmr_q <= tmr_d;
      crc_q <= crc_d;  lcc_q <= lcc_d;  head_char_q <= head_char_d;  prev_q <= prev_d;
      dirty_q <= dirty_d;  crc_pend_q <= crc_pend_d;  lcc_pend_q <= lcc_pend_d;  loaded_q <= loaded_d;
      head_wr_q <= head_wr_d;  ready_q <= ready_d;  gap_act_q <= gap_act_d;  rew_q <= rew_d;
      lp_q <= lp_s;
      te_q <= te_s;
      fwd_q <= fwd_d;
    end
  end

  // stepping oscillator; ramp restarts from the slow end whenever it idles
  tape_pkg::cnt_t per_q, per_d, ocnt_q, ocnt_d, opls_q, opls_d, mstep_q, mstep_d;
  logic osc_run, osc_out_q, motor_step_q;

  // runs for slew, loading, rewind and gaps
  assign osc_run  = (state_q == tape_pkg::S_LOADING) || (state_q == tape_pkg::S_REWIND) ||
                    (state_q == tape_pkg::S_GAP) ||
                    ((state_q == tape_pkg::S_READY) && (slew_s || (loaded_q && load_p)));
  assign osc_tick = osc_run && (ocnt_q >= per_q - ONE_C);

  always_comb begin
    per_d   = per_q;
    ocnt_d  = ocnt_q + ONE_C;
    opls_d  = (opls_q != '0) ? opls_q - ONE_C : '0;
    mstep_d = (mstep_q != '0) ? mstep_q - ONE_C : '0;
    if (!osc_run) begin
      per_d  = START_C;
      ocnt_d = '0;
    end else if (osc_tick) begin
      ocnt_d  = '0;
      per_d   = (per_q > PER_C + DEC_C) ? per_q - DEC_C : PER_C;
      opls_d  = PULSE_C;
      mstep_d = PULSE_C;
    end
    // incremental write steps the motor once per character
    if (step_take && !osc_run) begin
      mstep_d = PULSE_C;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      per_q <= START_C;  ocnt_q <= '0;  opls_q <= '0;  mstep_q <= '0;
      osc_out_q <= 1'b0;  motor_step_q <= 1'b0;
    end else if (ce) begin
      per_q <= per_d;  ocnt_q <= ocnt_d;  opls_q <= opls_d;  mstep_q <= mstep_d;
      // oscillator brought out as data clock
      osc_out_q    <= (opls_d != '0);
      motor_step_q <= (mstep_d != '0);
    end
  end

  // echo check window; a late fault in the clearing cycle still sets
  tape_pkg::cnt_t win_q, win_d;
  logic werr_q, werr_d;

  always_comb begin
    win_d  = step_take ? ECHO_C : ((win_q != '0) ? win_q - ONE_C : '0);
    werr_d = werr_q;
    // clear on next step, set wins
    if (step_take) begin
      werr_d = 1'b0;
    end
    if (win_q != '0 && echo_s) begin
      werr_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      win_q  <= '0;
      werr_q <= 1'b0;
    end else if (ce) begin
      win_q  <= win_d;
      werr_q <= werr_d;
    end
  end

  assign motor_step      = motor_step_q;
  assign motor_forward   = fwd_q;
  assign rewind_drive    = rew_q;
  assign head_write      = head_wr_q;
  assign head_char       = head_char_q;
  assign ready           = ready_q;
  assign gap_active      = gap_act_q;
  assign write_error     = werr_q;
  assign load_point      = lp_q;
  assign tape_end_marker = te_q;
  assign osc_out         = osc_out_q;

  sequence crc_slot_s;
    state_q == tape_pkg::S_GAP && gap_q != tape_pkg::G_MARK && osc_tick && crc_pend_q &&
      sp_n == tape_pkg::CRC_SPACE && !brk_s;
  endsequence
  sequence lcc_slot_s;
    state_q == tape_pkg::S_GAP && gap_q != tape_pkg::G_MARK && osc_tick && lcc_pend_q &&
      sp_n == tape_pkg::LCC_SPACE && !brk_s;
  endsequence

  crc_place_a: assert property (crc_slot_s |=> head_wr_q && head_char_q[7:0] == $past(crc_q))
    else $error("cyclic check not written at its space");
  lcc_place_a: assert property (lcc_slot_s |=> head_wr_q && head_char_q[7:0] == $past(lcc_q))
    else $error("longitudinal check not written at its space");
  // gap_q keeps its mark code after the gap, so data writes in ready must not count
  mark_char_a: assert property (head_wr_q && gap_q == tape_pkg::G_MARK && state_q == tape_pkg::S_GAP
    |-> head_char_q[7:0] == tape_pkg::MARK_CHAR)
    else $error("non-mark character written in mark sequence");
  parity_odd_a: assert property (head_wr_q |-> ^head_char_q)
    else $error("character parity is not odd");
  char_capture_a: assert property (step_take |=> head_wr_q && head_char_q[7:0] == $past(data_s))
    else $error("write step did not capture data");
  osc_pulse_a: assert property (osc_tick |=> osc_out_q [*8])
    else $error("oscillator pulse too short");
  broken_halt_a: assert property (brk_s |=> state_q == tape_pkg::S_UNLOADED && !ready_q && !gap_act_q)
    else $error("broken tape did not halt");
  rewind_stop_a: assert property (state_q == tape_pkg::S_REWIND && lp_s && !brk_s |=> !rew_q ##1 lp_q)
    else $error("rewind did not stop at load point");
  start_gap_a: assert property (state_q == tape_pkg::S_LOADING && lp_s && !brk_s
    |=> gap_act_q && gap_q == tape_pkg::G_BOT)
    else $error("no start gap at load point");
  stop_hold_a: assert property ($fell(gap_act_q)
    |-> $past(state_q) == tape_pkg::S_STOP || $past(brk_s) || $past(rew_p))
    else $error("gap-active dropped without stopping delay");
  err_clear_a: assert property (step_take && win_q == '0 |=> !werr_q)
    else $error("write error not cleared by write step");
  end_level_a: assert property (##1 te_q == $past(te_s))
    else $error("end marker level not followed");

endmodule // tape_write_gap_sequencer

// ### testbench/data_source.sv
// Purpose: far-side data source driving pulses and closures
// Assumes: 50 MHz mclk, all times in cycles
// Notes:   bench shortens eor_wait; real parts need 2 ms
`timescale 1ns/1ps
module data_source #(
  parameter int unsigned EOR_WAIT = 100000
) (
  input  wire logic mclk,
  output logic [7:0] data_in,
  output logic       write_step,
  output logic       end_record_command,
  output logic       load_forward_n,
  output logic       ready_button_n
);
  initial begin
    data_in = 8'h00;
    write_step = 1'b0;
    end_record_command = 1'b0;
    load_forward_n = 1'b1;
    ready_button_n = 1'b1;
  end
  // 20 us pulse, levels held 50 us
  task automatic write_char(input logic [7:0] d);
    data_in <= d;
    @(posedge mclk) write_step <= 1'b1;
    repeat (1000) @(posedge mclk);
    write_step <= 1'b0;
    repeat (1500) @(posedge mclk);
    // released lines must not keep the old value
    data_in <= ~d;
    @(posedge mclk);
  endtask
  // wait after last step, then pulse
  task automatic end_record;
    repeat (EOR_WAIT) @(posedge mclk);
    end_record_command <= 1'b1;
    repeat (1000) @(posedge mclk);
    end_record_command <= 1'b0;
  endtask
  task automatic press_ready;
    load_forward_n <= 1'b0;
    ready_button_n <= 1'b0;
    repeat (2000) @(posedge mclk);
    load_forward_n <= 1'b1;
    ready_button_n <= 1'b1;
  endtask
endmodule // data_source

// ### testbench/tape_write_gap_sequencer_bench.sv
// Purpose: self-checking bench for the write/gap sequencer
// Assumes: shortened step and delay parameters
// Notes:   full gaps exceed the run budget; only the first 9 spaces are watched
`timescale 1ns/1ps
module tape_write_gap_sequencer_bench;
  logic       mclk, rst, forward_select, load_point_sense, tape_end_sense, broken_tape_sense;
  logic       echo_fault, head_current_ok, write_step, end_record_command, load_forward_n, ready_button_n;
  logic [7:0] data_in;
  logic [8:0] head_char, last_char;
  logic       motor_step, motor_forward, head_write, ready, gap_active, write_error, load_point;
  logic       tape_end_marker, osc_out, ce, slew, end_file_command, rewind_n, file_gap_n, rewind_drive;
  int         n_errors, checks, osc_n, hw_n, hi, min_hi, cyc, o, n, ms_n, dclk_n, d;
  int         q[$];
  tape_write_gap_sequencer #(.STEP_PERIOD_CYC(520), .ACCEL_START_CYC(600), .ACCEL_DEC_CYC(10),
    .ECHO_WINDOW_CYC(200), .STOP_DELAY_CYC(50)) tape_write_gap_sequencer_i (.mclk(mclk), .rst(rst),
    .ce(ce), .data_in(data_in), .write_step(write_step), .end_record_command(end_record_command),
    .end_file_command(end_file_command), .forward_select(forward_select), .slew(slew),
    .load_point_sense(load_point_sense), .tape_end_sense(tape_end_sense),
    .broken_tape_sense(broken_tape_sense), .echo_fault(echo_fault), .head_current_ok(head_current_ok),
    .load_forward_n(load_forward_n), .rewind_n(rewind_n), .file_gap_n(file_gap_n),
    .ready_button_n(ready_button_n), .motor_step(motor_step), .motor_forward(motor_forward),
    .rewind_drive(rewind_drive), .head_write(head_write),
    .head_char(head_char), .ready(ready), .gap_active(gap_active), .write_error(write_error),
    .load_point(load_point), .tape_end_marker(tape_end_marker), .osc_out(osc_out));
  data_source #(.EOR_WAIT(2000)) data_source_i (.mclk(mclk), .data_in(data_in), .write_step(write_step),
    .end_record_command(end_record_command), .load_forward_n(load_forward_n),
    .ready_button_n(ready_button_n));
  always #10 mclk = ~mclk;
  always @(posedge osc_out) begin
    osc_n++;
    if (ready === 1'b1 && gap_active === 1'b0) dclk_n++;
  end
  always @(posedge motor_step) ms_n++;
  // pulse width and head writes seen from outside; cycle ceiling cuts hangs
  always @(posedge mclk) begin
    cyc++;
    if (head_write === 1'b1) begin
      hw_n++;
      last_char = head_char;
      q.push_back(osc_n);
    end
    if (osc_out === 1'b1) hi++;
    else begin
      if (hi != 0 && hi < min_hi) min_hi = hi;
      hi = 0;
    end
    if (cyc == 50000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_write;
    logic [7:0] v[3] = '{8'h00, 8'h01, 8'h7F};
    foreach (v[i]) begin
      n = hw_n;
      o = ms_n;
      data_source_i.write_char(v[i]);
      chk(16'(hw_n - n), 16'h0001);
      chk(16'(ms_n - o), 16'h0001);
      chk(16'(last_char), {7'h00, ~^v[i], v[i]});
    end
    $display("write test done");
  endtask
  task automatic t_error;
    echo_fault <= 1'b1;
    data_source_i.write_char(8'h3C);
    echo_fault <= 1'b0;
    chk(16'(write_error), 16'h0001);
    repeat (3000) @(posedge mclk);
    chk(16'(write_error), 16'h0001);
    data_source_i.write_char(8'h55);
    chk(16'(write_error), 16'h0000);
    $display("error test done");
  endtask
  task automatic t_sense;
    load_point_sense <= 1'b1;
    tape_end_sense <= 1'b1;
    forward_select <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(16'(load_point), 16'h0001);
    chk(16'(tape_end_marker), 16'h0001);
    chk(16'(ready), 16'h0001);
    chk(16'(motor_forward), 16'h0000);
    load_point_sense <= 1'b0;
    tape_end_sense <= 1'b0;
    forward_select <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(16'(load_point | tape_end_marker), 16'h0000);
    chk(16'(motor_forward), 16'h0001);
    head_current_ok <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(16'(ready), 16'h0000);
    head_current_ok <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(16'(ready), 16'h0001);
    $display("sense test done");
  endtask
  task automatic t_rewind;
    rewind_n <= 1'b0;
    repeat (1000) @(posedge mclk);
    rewind_n <= 1'b1;
    chk(16'({rewind_drive, motor_forward, ready}), 16'h0004);
    // frozen clock enable must hide the marker
    ce <= 1'b0;
    load_point_sense <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(16'(rewind_drive), 16'h0001);
    ce <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(16'({rewind_drive, load_point, ready}), 16'h0002);
    load_point_sense <= 1'b0;
    data_source_i.press_ready();
    repeat (600) @(posedge mclk);
    chk(16'(ready), 16'h0001);
    $display("rewind test done");
  endtask
  task automatic t_slew;
    o = dclk_n;
    n = ms_n;
    slew <= 1'b1;
    repeat (1300) @(posedge mclk);
    slew <= 1'b0;
    chk(16'(dclk_n - o), 16'h0002);
    chk(16'(ms_n - n), 16'h0002);
    $display("slew test done");
  endtask
  task automatic t_file;
    broken_tape_sense <= 1'b0;
    repeat (20) @(posedge mclk);
    data_source_i.press_ready();
    repeat (20) @(posedge mclk);
    end_file_command <= 1'b1;
    repeat (1000) @(posedge mclk);
    end_file_command <= 1'b0;
    chk(16'({ready, gap_active}), 16'h0003);
    broken_tape_sense <= 1'b1;
    repeat (20) @(posedge mclk);
    broken_tape_sense <= 1'b0;
    repeat (20) @(posedge mclk);
    data_source_i.press_ready();
    repeat (20) @(posedge mclk);
    file_gap_n <= 1'b0;
    repeat (1000) @(posedge mclk);
    file_gap_n <= 1'b1;
    chk(16'({ready, gap_active}), 16'h0003);
    $display("file test done");
  endtask
  task automatic t_gap;
    n = hw_n;
    o = osc_n;
    d = dclk_n;
    q.delete();
    data_source_i.end_record();
    chk(16'(gap_active), 16'h0001);
    data_source_i.write_char(8'h11);
    for (int i = 0; i < 8000 && osc_n - o < 9; i++) @(posedge mclk);
    chk(16'(hw_n - n), 16'h0002);
    chk(16'(q[0] - o), 16'h0004);
    chk(16'(q[1] - o), 16'h0008);
    chk(16'(^last_char), 16'h0001);
    chk(16'(min_hi >= 500), 16'h0001);
    chk(16'(dclk_n - d), 16'h0000);
    chk(16'(gap_active), 16'h0001);
    broken_tape_sense <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(16'(gap_active | ready), 16'h0000);
    $display("gap test done");
  endtask
  initial begin
    {mclk, forward_select, rst} = 3'b011;
    {ce, slew, end_file_command, rewind_n, file_gap_n} = 5'h13;
    {load_point_sense, tape_end_sense, broken_tape_sense, echo_fault, head_current_ok} = 5'h01;
    min_hi = 1 << 20;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(16'({motor_forward, ready, gap_active}), 16'h0004);
    data_source_i.press_ready();
    // let the loading slew pulse die out before counting motor steps
    repeat (600) @(posedge mclk);
    chk(16'({ready, gap_active}), 16'h0002);
    t_write();
    t_error();
    t_sense();
    t_rewind();
    t_slew();
    t_gap();
    t_file();
    test_done();
  end
endmodule // tape_write_gap_sequencer_bench
